/* File: logic/sw_link_pkg.sv */
// Shared constants for the single-wire humidity/temperature readout link
package sw_link_pkg;
  // Clock rate
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned NS_PER_CYC = 25;
  // Times as printed, in microseconds (spacing and power-up in milliseconds)
  localparam int unsigned START_MIN_US = 1000;
  localparam int unsigned ACK_LOW_US = 80;
  localparam int unsigned ACK_HIGH_US = 80;
  localparam int unsigned BIT_LOW_US = 50;
  localparam int unsigned BIT_H0_US = 26;
  localparam int unsigned BIT_H1_US = 70;
  localparam int unsigned END_LOW_US = 50;
  localparam int unsigned SPACING_MS = 2000;
  localparam int unsigned POWERUP_MS = 2000;
  localparam int unsigned TIMEOUT_US = 200;
  // Decision threshold between zero and one high times
  localparam int unsigned BIT_SPLIT_US = 48;
  // Least start length that the sensor accepts
  localparam int unsigned START_ACCEPT_US = 800;
  // Cycle counts derived from the times
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned START_CYC = START_MIN_US * CYC_PER_US;
  localparam int unsigned START_ACCEPT_CYC = START_ACCEPT_US * CYC_PER_US;
  localparam int unsigned ACK_LOW_CYC = ACK_LOW_US * CYC_PER_US;
  localparam int unsigned ACK_HIGH_CYC = ACK_HIGH_US * CYC_PER_US;
  localparam int unsigned BIT_LOW_CYC = BIT_LOW_US * CYC_PER_US;
  localparam int unsigned BIT_H0_CYC = BIT_H0_US * CYC_PER_US;
  localparam int unsigned BIT_H1_CYC = BIT_H1_US * CYC_PER_US;
  localparam int unsigned END_LOW_CYC = END_LOW_US * CYC_PER_US;
  localparam int unsigned TIMEOUT_CYC = TIMEOUT_US * CYC_PER_US;
  localparam int unsigned BIT_SPLIT_CYC = BIT_SPLIT_US * CYC_PER_US;
  // Long counts, defaults of top parameters
  localparam int unsigned SPACING_CYC = SPACING_MS * 1000 * CYC_PER_US;
  localparam int unsigned POWERUP_CYC = POWERUP_MS * 1000 * CYC_PER_US;
  // Frame layout
  localparam int unsigned FRAME_BITS = 40;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned FIELD_W = 16;
  localparam int unsigned SIGN_BIT = 15;
  localparam int unsigned CNT_W = 32;
  // Wishbone map of the host controller (byte addresses, one word apart)
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_STATUS = 4'h4;
  localparam logic [3:0] ADR_HUM = 4'h8;
  localparam logic [3:0] ADR_TEMP = 4'hC;
  localparam int unsigned CTRL_GO = 0;
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_DONE = 1;
  localparam int unsigned ST_CSUM_ERR = 2;
  localparam int unsigned ST_TIMEOUT = 3;
  localparam int unsigned ST_READY = 4;

  // Additive checksum over the four data bytes, carry discarded
  function automatic logic [7:0] frame_sum(input logic [31:0] d);
    frame_sum = d[31:24] + d[23:16] + d[15:8] + d[7:0];
  endfunction
endpackage

/* File: logic/sw_link_if.sv */
// Open-drain single data line joining sensor and host
`timescale 1ns/100ps
interface sw_link_if;
  logic dev_oe;
  logic dev_out;
  logic host_oe;
  logic host_out;
  wire logic line;

  // Pull-up: low only while someone drives low
  assign line = !((dev_oe && !dev_out) || (host_oe && !host_out));

  modport device (output dev_oe, output dev_out, input line);
  modport host (output host_oe, output host_out, input line);
endinterface

/* File: logic/sensor_end.sv */
// Sensor end of the single-wire link: answers start pulses with a 40-bit frame
//
// Overview of operation
// - Host starts with at least 1 ms low
// - Sensor answers 80 us low, 80 us high
// - Exactly forty bits, MSB first, per transaction
// - Humidity is 16-bit unsigned, tenths of percent
// - Temperature sign-magnitude, bit 15 negative
// - Temperature magnitude in tenths of degree
// - Last byte is the four-byte sum
// - Sensor only answers valid start, else silent
// - Host drives only open-drain, releases when idle
// - Sensor data pin is tri-state capable
// - Host spaces reads at least two seconds
// - Host waits two seconds after power-up
// - Frame carries previous stored measurement
// - Host keeps active time under ten percent
// - Bit: 50 us low, 26/70 us high
// - Byte order: humH, humL, tmpH, tmpL, sum
// - After bit 40: 50 us low, release, measure
// - Host discards frame on checksum mismatch
`timescale 1ns/100ps
module sensor_end #(
  parameter int unsigned START_ACCEPT = sw_link_pkg::START_ACCEPT_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Measurement source
  input wire logic [15:0] hum_in,
  input wire logic temp_neg_in,
  input wire logic [14:0] temp_mag_in,
  // Status
  output logic busy_out,
  // Link
  sw_link_if.device link
);
  typedef enum logic [2:0] {S_IDLE, S_START, S_ACK_LO, S_ACK_HI, S_BIT_LO, S_BIT_HI,
    S_END_LO} dev_state_e;

  dev_state_e state_reg;
  logic [31:0] cnt_reg;
  logic [5:0] bit_reg;
  logic [39:0] frame_reg;
  logic [31:0] meas_reg;
  logic drive_low_reg;
  logic busy_reg;
  logic cur_bit;

  assign cur_bit = frame_reg[sw_link_pkg::FRAME_BITS - 1];

  // ----------------------------------------------
  // Stored measurement
  // ----------------------------------------------
  // Capture after a frame
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meas_reg <= 32'h0;
    end else if (state_reg == S_END_LO && cnt_reg == 32'(sw_link_pkg::END_LOW_CYC - 1)) begin
      meas_reg <= {hum_in, temp_neg_in, temp_mag_in};
    end
  end

  // ----------------------------------------------
  // Link sequencer
  // ----------------------------------------------
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= S_IDLE;
      cnt_reg <= 32'h0;
      bit_reg <= 6'h0;
      frame_reg <= 40'h0;
    end else begin
      unique case (state_reg)
        S_IDLE: begin
          cnt_reg <= 32'h0;
          if (!link.line) begin
            state_reg <= S_START;
          end
        end
        S_START: begin
          // Too short a low is ignored
          if (link.line) begin
            cnt_reg <= 32'h0;
            state_reg <= (cnt_reg >= 32'(START_ACCEPT)) ? S_ACK_LO : S_IDLE;
            frame_reg <= {meas_reg, sw_link_pkg::frame_sum(meas_reg)};
          end else if (cnt_reg != 32'hFFFFFFFF) begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        S_ACK_LO: begin
          if (cnt_reg == 32'(sw_link_pkg::ACK_LOW_CYC - 1)) begin
            cnt_reg <= 32'h0;
            state_reg <= S_ACK_HI;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        S_ACK_HI: begin
          if (cnt_reg == 32'(sw_link_pkg::ACK_HIGH_CYC - 1)) begin
            cnt_reg <= 32'h0;
            bit_reg <= 6'h0;
            state_reg <= S_BIT_LO;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        S_BIT_LO: begin
          if (cnt_reg == 32'(sw_link_pkg::BIT_LOW_CYC - 1)) begin
            cnt_reg <= 32'h0;
            state_reg <= S_BIT_HI;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        S_BIT_HI: begin
          if (cnt_reg == (cur_bit ? 32'(sw_link_pkg::BIT_H1_CYC - 1)
                                  : 32'(sw_link_pkg::BIT_H0_CYC - 1))) begin
            cnt_reg <= 32'h0;
            frame_reg <= {frame_reg[38:0], 1'b0};
            bit_reg <= bit_reg + 6'h1;
            state_reg <= (bit_reg == 6'(sw_link_pkg::FRAME_BITS - 1)) ? S_END_LO : S_BIT_LO;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        S_END_LO: begin
          if (cnt_reg == 32'(sw_link_pkg::END_LOW_CYC - 1)) begin
            cnt_reg <= 32'h0;
            state_reg <= S_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------
  // Pin drive
  // ----------------------------------------------
  // Drive low only in low phases, else release
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      drive_low_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      drive_low_reg <= (state_reg == S_START && link.line && cnt_reg >= 32'(START_ACCEPT))
        || (state_reg == S_ACK_LO && cnt_reg != 32'(sw_link_pkg::ACK_LOW_CYC - 1))
        || (state_reg == S_ACK_HI && cnt_reg == 32'(sw_link_pkg::ACK_HIGH_CYC - 1))
        || (state_reg == S_BIT_LO && cnt_reg != 32'(sw_link_pkg::BIT_LOW_CYC - 1))
        || (state_reg == S_BIT_HI && cnt_reg == (cur_bit ? 32'(sw_link_pkg::BIT_H1_CYC - 1)
                                                         : 32'(sw_link_pkg::BIT_H0_CYC - 1)))
        || (state_reg == S_END_LO && cnt_reg != 32'(sw_link_pkg::END_LOW_CYC - 1));
      busy_reg <= (state_reg != S_IDLE && state_reg != S_START);
    end
  end

  assign link.dev_oe = drive_low_reg;
  assign link.dev_out = 1'b0;
  assign busy_out = busy_reg;
endmodule

/* File: logic/host_end.sv */
// Host end of the single-wire link with a classic Wishbone register slave
`timescale 1ns/100ps
module host_end #(
  parameter int unsigned SPACING = sw_link_pkg::SPACING_CYC,
  parameter int unsigned POWERUP = sw_link_pkg::POWERUP_CYC
) (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Wishbone slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Link
  sw_link_if.host link
);
  typedef enum logic [2:0] {H_WAIT, H_IDLE, H_START, H_RESP, H_BITS, H_END}
    host_state_e;

  host_state_e state_reg;
  logic [31:0] cnt_reg;
  logic [31:0] gap_reg;
  logic [5:0] bit_reg;
  logic [39:0] shift_reg;
  logic [2:0] edge_reg;
  logic line_d_reg;
  logic go_reg;
  logic done_reg;
  logic csum_err_reg;
  logic timeout_reg;
  logic [31:0] data_reg;
  logic wb_ack_reg;
  logic [31:0] wb_dat_reg;
  logic wb_hit;
  logic fall;
  logic rise;
  logic [31:0] rx_data;

  assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_reg;
  assign fall = line_d_reg && !link.line;
  assign rise = !line_d_reg && link.line;
  assign rx_data = shift_reg[39:8];

  // Bus write of GO bit
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      go_reg <= 1'b0;
    end else if (wb_hit && wb_we_in && wb_sel_in[0] && wb_adr_in == sw_link_pkg::ADR_CTRL
                 && wb_dat_in[sw_link_pkg::CTRL_GO]) begin
      go_reg <= 1'b1;
    end else if (state_reg == H_IDLE && gap_reg == 32'h0) begin
      go_reg <= 1'b0;
    end
  end

  // Link sequencer
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= H_WAIT;
      cnt_reg <= 32'h0;
      gap_reg <= 32'h0;
      bit_reg <= 6'h0;
      shift_reg <= 40'h0;
      edge_reg <= 3'h0;
      line_d_reg <= 1'b1;
      done_reg <= 1'b0;
      csum_err_reg <= 1'b0;
      timeout_reg <= 1'b0;
      data_reg <= 32'h0;
    end else begin
      line_d_reg <= link.line;
      if (gap_reg != 32'h0) begin
        gap_reg <= gap_reg - 32'h1;
      end
      unique case (state_reg)
        H_WAIT: begin
          if (cnt_reg >= 32'(POWERUP)) begin
            cnt_reg <= 32'h0;
            state_reg <= H_IDLE;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        H_IDLE: begin
          cnt_reg <= 32'h0;
          if (go_reg && gap_reg == 32'h0) begin
            done_reg <= 1'b0;
            csum_err_reg <= 1'b0;
            timeout_reg <= 1'b0;
            gap_reg <= 32'(SPACING);
            state_reg <= H_START;
          end
        end
        H_START: begin
          // Hold line low for start length
          if (cnt_reg == 32'(sw_link_pkg::START_CYC - 1)) begin
            cnt_reg <= 32'h0;
            edge_reg <= 3'h0;
            state_reg <= H_RESP;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        H_RESP: begin
          // Falls: answer low, then first bit low
          cnt_reg <= (fall || rise) ? 32'h0 : cnt_reg + 32'h1;
          if (fall) begin
            edge_reg <= edge_reg + 3'h1;
            if (edge_reg == 3'h1) begin
              bit_reg <= 6'h0;
              state_reg <= H_BITS;
            end
          end
          if (cnt_reg == 32'(sw_link_pkg::TIMEOUT_CYC)) begin
            timeout_reg <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        H_BITS: begin
          cnt_reg <= (rise || fall) ? 32'h0 : cnt_reg + 32'h1;
          // High length decides the bit
          if (fall && link.line == 1'b0 && edge_reg == 3'h3) begin
            shift_reg <= {shift_reg[38:0], cnt_reg >= 32'(sw_link_pkg::BIT_SPLIT_CYC)};
            bit_reg <= bit_reg + 6'h1;
            if (bit_reg == 6'(sw_link_pkg::FRAME_BITS - 1)) begin
              state_reg <= H_END;
            end
          end
          edge_reg <= rise ? 3'h3 : (fall ? 3'h2 : edge_reg);
          if (cnt_reg == 32'(sw_link_pkg::TIMEOUT_CYC)) begin
            timeout_reg <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        H_END: begin
          // Check sum, keep data only if good
          done_reg <= 1'b1;
          if (sw_link_pkg::frame_sum(rx_data) == shift_reg[7:0]) begin
            data_reg <= rx_data;
          end else begin
            csum_err_reg <= 1'b1;
          end
          state_reg <= H_IDLE;
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // Open-drain: drive only low, only during start
  assign link.host_oe = (state_reg == H_START);
  assign link.host_out = 1'b0;

  // Wishbone read and ack, one cycle after request
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0;
    end else begin
      wb_ack_reg <= wb_hit;
      if (wb_hit) begin
        unique case (wb_adr_in)
          sw_link_pkg::ADR_CTRL: wb_dat_reg <= {31'h0, go_reg};
          sw_link_pkg::ADR_STATUS: wb_dat_reg <= {27'h0, state_reg == H_IDLE && gap_reg == 32'h0,
            timeout_reg, csum_err_reg, done_reg, state_reg != H_IDLE && state_reg != H_WAIT};
          sw_link_pkg::ADR_HUM: wb_dat_reg <= {16'h0, data_reg[31:16]};
          sw_link_pkg::ADR_TEMP: wb_dat_reg <= {16'h0, data_reg[15:0]};
          default: wb_dat_reg <= 32'h0;
        endcase
      end
    end
  end

  assign wb_ack_out = wb_ack_reg;
  assign wb_dat_out = wb_dat_reg;
endmodule

/* File: verif/sw_link_sva.sv */
// Timing checks on the shared single data line
`timescale 1ns/100ps
module sw_link_sva (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic nrst_in,
  // Line signals
  input wire logic dev_oe,
  input wire logic dev_out,
  input wire logic host_oe,
  input wire logic host_out,
  input wire logic line
);
  int unsigned host_run, low_run, gap_run, rises;
  logic in_frame;

  // ----------------------------------------
  // Run-length helpers
  // ----------------------------------------
  // Counters stand in for long repetitions
  always_ff @(posedge core_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      host_run <= 0;
      low_run <= 0;
      gap_run <= 0;
      rises <= 0;
      in_frame <= 1'b0;
    end else begin
      host_run <= host_oe ? host_run + 1 : 0;
      low_run <= dev_oe ? low_run + 1 : 0;
      gap_run <= dev_oe ? 0 : gap_run + 1;
      rises <= host_oe ? 0 : rises + 32'($rose(dev_oe));
      in_frame <= host_oe ? 1'b0 : (dev_oe ? 1'b1 : in_frame);
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);

  // ----------------------------------------
  // Line assertions
  // ----------------------------------------
  a_drive_low_only: assert property (dev_oe |-> !dev_out)
    else $error("sensor drives line high");
  a_one_talker: assert property (host_oe |-> !dev_oe)
    else $error("sensor drives during start");
  a_start_length: assert property ($fell(host_oe) |-> host_run >= sw_link_pkg::START_CYC)
    else $error("start pulse too short");
  a_low_length: assert property ($fell(dev_oe) |-> low_run inside {[1800:2200], [3000:3400]})
    else $error("sensor low period out of range");
  a_high_length: assert property ($rose(dev_oe) && in_frame |->
    gap_run inside {[880:1200], [2720:3400]})
    else $error("high period out of range");
  a_bit_count: assert property ($rose(host_oe) |-> rises == 0 || rises == 42)
    else $error("wrong number of low pulses in frame");
  // Sensor pulls low on the same edge at which it sees the released line
  a_answer_bound: assert property ($fell(host_oe) |-> ##[1:8] dev_oe)
    else $error("no answer after start");
  a_end_release: assert property ($fell(dev_oe) && rises == 42 |-> !dev_oe [*8])
    else $error("sensor drives after end of frame");
endmodule

/* File: verif/tb_top.sv */
// Self-checking bench joining host and sensor ends over the shared line
`timescale 1ns/100ps
module tb_top;
  logic core_clk_in, nrst_in, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [3:0] wb_adr;
  logic [31:0] wb_wdat, wb_rdat, rd;
  logic [15:0] hum;
  logic neg, busy, busy_b, seen_b, line_q;
  logic [14:0] mag;
  logic [39:0] wire_frame, exp_frame;
  logic [7:0] sum;
  int hi_run, wire_bits, mismatches, total_checks, n_wait;

  sw_link_if lnk();
  sw_link_if lnk_b();
  host_end #(.SPACING(100000), .POWERUP(100)) i_host_end (.core_clk_in(core_clk_in),
    .nrst_in(nrst_in), .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_sel_in(4'hF), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack), .link(lnk.host));
  sensor_end i_sensor_end (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .hum_in(hum),
    .temp_neg_in(neg), .temp_mag_in(mag), .busy_out(busy), .link(lnk.device));
  // Second sensor faces a bench driver that sends a too-short start, then a valid one
  sensor_end i_sensor_end_b (.core_clk_in(core_clk_in), .nrst_in(nrst_in), .hum_in(hum),
    .temp_neg_in(neg), .temp_mag_in(mag), .busy_out(busy_b), .link(lnk_b.device));
  sw_link_sva i_sw_link_sva (.core_clk_in(core_clk_in), .nrst_in(nrst_in),
    .dev_oe(lnk.dev_oe), .dev_out(lnk.dev_out), .host_oe(lnk.host_oe),
    .host_out(lnk.host_out), .line(lnk.line));

  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  // ----------------------------------------
  // Wire monitor
  // ----------------------------------------
  // Long high before a fall marks the handshake, so the bit count restarts there
  always @(posedge core_clk_in) begin
    line_q <= lnk.line;
    hi_run <= lnk.line ? hi_run + 1 : 0;
    if (lnk_b.dev_oe || busy_b) seen_b <= 1'b1;
    if (line_q && !lnk.line && lnk.dev_oe) begin
      if (hi_run >= 3000) wire_bits <= 0;
      else begin
        wire_frame <= {wire_frame[38:0], hi_run > 1920};
        wire_bits <= wire_bits + 1;
      end
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    @(posedge core_clk_in);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    n = 0;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (n >= 50) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic wait_flag(input int b);
    int n;
    n = 0;
    do begin
      wb(1'b0, sw_link_pkg::ADR_STATUS, 32'h0);
      n++;
    end while (rd[b] !== 1'b1 && n < 150000);
    if (n >= 150000) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  task automatic pulse_b(input int len);
    lnk_b.host_oe <= 1'b1;
    repeat (len) @(posedge core_clk_in);
    lnk_b.host_oe <= 1'b0;
    repeat (9000) @(posedge core_clk_in);
  endtask

  task automatic read_cycle(input logic [39:0] exp);
    wait_flag(sw_link_pkg::ST_READY);
    wb(1'b1, sw_link_pkg::ADR_CTRL, 32'h1);
    wait_flag(sw_link_pkg::ST_BUSY);
    wait_flag(sw_link_pkg::ST_DONE);
    wb(1'b0, sw_link_pkg::ADR_HUM, 32'h0);
    check(40'(rd), 40'(exp[39:24]));
    wb(1'b0, sw_link_pkg::ADR_TEMP, 32'h0);
    check(40'(rd), 40'(exp[23:8]));
    wb(1'b0, sw_link_pkg::ADR_STATUS, 32'h0);
    check(40'(rd[sw_link_pkg::ST_CSUM_ERR]), 40'h0);
    check(40'(wire_bits), 40'h28);
    check(wire_frame, exp);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    nrst_in = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_wdat = 32'h0;
    hum = 16'h0292;
    neg = 1'b1;
    mag = 15'h0065;
    seen_b = 1'b0;
    lnk_b.host_oe = 1'b0;
    lnk_b.host_out = 1'b0;
    repeat (8) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    wb(1'b0, 4'h2, 32'h0);
    check(40'(rd), 40'h0);
    wb(1'b1, sw_link_pkg::ADR_HUM, 32'hFFFFFFFF);
    wb(1'b0, sw_link_pkg::ADR_HUM, 32'h0);
    check(40'(rd), 40'h0);
    pulse_b(20000);
    check(40'(seen_b), 40'h0);
    pulse_b(40000);
    check(40'(seen_b), 40'h1);
    read_cycle(40'h0);
    // Carry out of the byte sum is dropped
    sum = hum[15:8] + hum[7:0] + {neg, mag[14:8]} + mag[7:0];
    exp_frame = {hum, neg, mag, sum};
    // Sensor samples its inputs at the end of the trailing low, after done shows
    n_wait = 0;
    while (busy !== 1'b0 && n_wait < 10000) begin
      @(posedge core_clk_in);
      n_wait++;
    end
    check(40'(busy), 40'h0);
    @(posedge core_clk_in);
    hum <= 16'h03E7;
    neg <= 1'b0;
    mag <= 15'h0320;
    read_cycle(exp_frame);
    tally_and_finish();
  end
endmodule
